// ==== hw/dow_pkg.sv ====
// constants, types and option decoding for the option word decoder
//
// Contract
// - programmed bit reads 0, erased reads 1
// - option word lives at location 2007h
// - 2000h-3FFFh reachable only in programming mode
// - bit 11 enables fail-safe clock monitor
// - bit 10 enables internal/external switchover
// - brown-out code 11 always on, 00 off
// - code 10 off in sleep, 01 software
// - bit 7 low protects data memory
// - bit 6 low protects program memory
// - lifting data protection erases data EEPROM
// - lifting code protection erases program memory
// - bit 5 picks reset pin or input
// - bit 4 low enables power-up timer
// - bit 3 high enables watchdog timer
// - bits 2-0 select the oscillator mode
// - brown-out enable never enables power-up timer
// - reset held in RC/internal stops oscillator
// - power-up timer holds reset 64 ms
// - start-up timer waits for stable crystal
// - brown-out restarts power-up timer 64 ms
// - wake from sleep on three causes
// - software brown-out enable at power control bit 4
// - power-up timer counts 31 kHz ticks
package dow_pkg;

	// -------------------------------------------------------------------
	// address map
	// -------------------------------------------------------------------
	localparam logic [13:0] OPT_ADDR = 14'h2007; // option word location
	localparam logic [13:0] CFG_LO   = 14'h2000; // configuration space base
	localparam logic [13:0] CFG_HI   = 14'h3FFF; // configuration space top

	// -------------------------------------------------------------------
	// field positions and values
	// -------------------------------------------------------------------
	localparam int B_FCM   = 11; // fail-safe monitor enable
	localparam int B_INT_EXT_SWITCHOVER_ENABLE  = 10; // switchover enable
	localparam int B_BOR   = 8;  // brown-out select, two bits
	localparam int B_CPD   = 7;  // data protect, low active
	localparam int B_CP    = 6;  // program protect, low active
	localparam int B_RESET_PIN_SELECT = 5;  // reset pin select
	localparam int B_POWERUP_TIMER_DISABLE = 4;  // power-up timer disable
	localparam int B_WATCHDOG_ENABLE  = 3;  // watchdog enable
	localparam int B_FOSC  = 0;  // oscillator select, three bits
	localparam int B_SBOR  = 4;  // software brown-out bit in power control
	localparam logic [13:0] ERASED_WORD = 14'h3FFF; // all bits unprogrammed
	localparam logic        BIT_PROG    = 1'h0;     // programmed level

	localparam logic [1:0] BOR_ON  = 2'h3; // always on
	localparam logic [1:0] BOR_RUN = 2'h2; // on while running
	localparam logic [1:0] BOR_SW  = 2'h1; // software controlled
	localparam logic [1:0] BOR_OFF = 2'h0; // disabled

	localparam logic [2:0] OSC_LP = 3'h0; // low-power crystal
	localparam logic [2:0] OSC_XT = 3'h1; // standard crystal
	localparam logic [2:0] OSC_HS = 3'h2; // high-speed crystal
	localparam logic [2:0] OSC_EC = 3'h3; // external clock input
	localparam logic [2:0] OSC_RC = 3'h4; // first RC/internal code

	// -------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------
	localparam int POWERUP_TIMER_MS    = 64; // power-up timer delay, ms
	localparam int LF_KHZ     = 31; // low-frequency time base, kHz
	localparam int POWERUP_TIMER_TICKS = POWERUP_TIMER_MS * LF_KHZ; // ticks of time base

	// -------------------------------------------------------------------
	// types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic       failsafe_monitor_enable;
		logic       int_ext_switchover_enable;
		logic [1:0] brownout_select;
		logic       data_protect_n;
		logic       program_protect_n;
		logic       reset_pin_select;
		logic       powerup_timer_disable;
		logic       watchdog_enable;
		logic [2:0] osc_select;
	} dow_opt_t;

	typedef enum logic [3:0] {
		RS_HOLD = 4'h1, // power or brown-out hold
		RS_POWERUP_TIMER = 4'h2, // power-up timer running
		RS_OST  = 4'h4, // waiting for crystal
		RS_RUN  = 4'h8  // released
	} dow_rst_t;

	typedef enum logic [2:0] {
		PG_IDLE  = 3'h1, // waiting for programmer
		PG_ERASE = 3'h2, // erasing before unprotect
		PG_WRITE = 3'h4  // committing new word
	} dow_pg_t;

	// split a raw word into fields; bits 13-12 are dropped
	function automatic dow_opt_t dow_decode(input logic [13:0] w);
		dow_opt_t o;
		o.failsafe_monitor_enable   = w[B_FCM];
		o.int_ext_switchover_enable = w[B_INT_EXT_SWITCHOVER_ENABLE];
		o.brownout_select           = w[B_BOR+:2];
		o.data_protect_n            = w[B_CPD];
		o.program_protect_n         = w[B_CP];
		o.reset_pin_select          = w[B_RESET_PIN_SELECT];
		o.powerup_timer_disable     = w[B_POWERUP_TIMER_DISABLE];
		o.watchdog_enable           = w[B_WATCHDOG_ENABLE];
		o.osc_select                = w[B_FOSC+:3];
		return o;
	endfunction : dow_decode

endpackage : dow_pkg

// ==== hw/dow_top.sv ====
// option word decoder with programming port and reset sequencer
`timescale 1ns/100ps
module dow_top #(
	parameter int CNT_W      = 11,               // power-up counter width
	parameter int POWERUP_TIMER_COUNT = dow_pkg::POWERUP_TIMER_TICKS // ticks per time-out
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [13:0]      nvm_word,
	input  wire logic             prog_mode,
	input  wire logic [13:0]      prog_addr,
	input  wire logic [13:0]      prog_wdata,
	input  wire logic             prog_wr,
	input  wire logic             prog_rd,
	output logic      [13:0]      prog_rdata_ff,
	output logic                  prog_ack_ff,
	output logic                  nvm_wr_ff,
	output logic      [13:0]      nvm_wdata_ff,
	output logic                  data_erase_ff,
	output logic                  code_erase_ff,
	input  wire logic             erase_done,
	input  wire logic [13:0]      cpu_addr,
	input  wire logic             cpu_fetch,
	output logic                  cpu_blocked_ff,
	input  wire logic             por_event,
	input  wire logic             vdd_low,
	input  wire logic             lf_tick,
	input  wire logic             osc_stable,
	input  wire logic             ext_reset_pin,
	input  wire logic             sleeping,
	input  wire logic             wdt_wake,
	input  wire logic             irq_wake,
	input  wire logic [7:0]       power_control_reg,
	output dow_pkg::dow_opt_t     opt_ff,
	output logic                  bor_active_ff,
	output logic                  powerup_timer_active_ff,
	output logic                  ost_active_ff,
	output logic                  dev_reset_ff,
	output logic                  gpio_in_ff,
	output logic                  osc_stop_ff,
	output logic                  wake_ff,
	output logic                  wdt_run_ff
);

	// -------------------------------------------------------------------
	// elaboration checks
	// -------------------------------------------------------------------
	// counter must hold the full time-out
	if (POWERUP_TIMER_COUNT < 1 || POWERUP_TIMER_COUNT >= (1 << CNT_W)) begin : g_chk
		$error("POWERUP_TIMER_COUNT does not fit CNT_W");
	end

	localparam logic [CNT_W-1:0] POWERUP_TIMER_LAST = CNT_W'(POWERUP_TIMER_COUNT - 1);

	// -------------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------------
	dow_pkg::dow_pg_t  pg_ff;        // programming state
	dow_pkg::dow_pg_t  nxt_pg;       // next programming state
	dow_pkg::dow_rst_t rs_ff;        // reset sequencer state
	dow_pkg::dow_rst_t nxt_rs;       // next sequencer state
	logic [13:0]       wbuf_ff;      // word waiting to be committed
	logic [CNT_W-1:0]  powerup_timer_cnt_ff;  // power-up tick counter
	logic              opt_hit;      // programmer addresses the word
	logic              lift_data;    // write unprotects data memory
	logic              lift_code;    // write unprotects program memory
	logic              external_reset_n_n;       // internal reset line, low active
	logic              bor_on;       // brown-out detection armed
	logic              brown;        // brown-out condition now
	logic              crystal;      // crystal mode selected
	logic              sw_bor;       // software brown-out enable

	// -------------------------------------------------------------------
	// option capture
	// -------------------------------------------------------------------
	// sample the fuse word while reset is held, then freeze it
	always_ff @(posedge mclk) begin
		if (rst) begin
			opt_ff <= dow_pkg::dow_decode(nvm_word);
		end
	end

	// -------------------------------------------------------------------
	// field interpretation
	// -------------------------------------------------------------------
	// software enable sits in the power control register
	assign sw_bor = power_control_reg[dow_pkg::B_SBOR];

	// brown-out detection by select code
	always_comb begin
		case (opt_ff.brownout_select)
			dow_pkg::BOR_ON:  bor_on = 1'b1;
			dow_pkg::BOR_RUN: bor_on = !sleeping;
			dow_pkg::BOR_SW:  bor_on = sw_bor;
			default:          bor_on = 1'b0;
		endcase
	end

	// only armed detection turns a low supply into a reset
	assign brown = vdd_low && bor_on;

	// the three crystal modes need the start-up timer
	assign crystal = (opt_ff.osc_select == dow_pkg::OSC_LP) ||
	                 (opt_ff.osc_select == dow_pkg::OSC_XT) ||
	                 (opt_ff.osc_select == dow_pkg::OSC_HS);

	// pin acts as reset only when selected, else line stays high
	assign external_reset_n_n = opt_ff.reset_pin_select ? ext_reset_pin
	                                        : 1'b1;

	// -------------------------------------------------------------------
	// decoded device-wide outputs
	// -------------------------------------------------------------------
	// brown-out enable flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			bor_active_ff <= 1'b0;
		end else begin
			bor_active_ff <= bor_on;
		end
	end

	// watchdog runs only when its bit is set
	always_ff @(posedge mclk) begin
		if (rst) begin
			wdt_run_ff <= 1'b0;
		end else begin
			wdt_run_ff <= opt_ff.watchdog_enable == !dow_pkg::BIT_PROG;
		end
	end

	// pin value as digital input when not a reset pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			gpio_in_ff <= 1'b0;
		end else if (!opt_ff.reset_pin_select) begin
			gpio_in_ff <= ext_reset_pin;
		end else begin
			gpio_in_ff <= 1'b0; // pin owned by reset
		end
	end

	// stop the internal oscillator while reset holds in RC modes
	always_ff @(posedge mclk) begin
		if (rst) begin
			osc_stop_ff <= 1'b0;
		end else begin
			osc_stop_ff <= !external_reset_n_n &&
			               (opt_ff.osc_select >= dow_pkg::OSC_RC);
		end
	end

	// leave sleep on external reset, watchdog or interrupt
	always_ff @(posedge mclk) begin
		if (rst) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= sleeping && (!external_reset_n_n || wdt_wake || irq_wake);
		end
	end

	// -------------------------------------------------------------------
	// reset sequencer
	// -------------------------------------------------------------------
	// hold, then power-up timer, then start-up timer, then run
	always_comb begin
		nxt_rs = rs_ff;
		case (rs_ff)
			dow_pkg::RS_HOLD: begin
				if (!brown) begin
					// timer follows its own bit only
					if (opt_ff.powerup_timer_disable == dow_pkg::BIT_PROG) begin
						nxt_rs = dow_pkg::RS_POWERUP_TIMER;
					end else if (crystal) begin
						nxt_rs = dow_pkg::RS_OST;
					end else begin
						nxt_rs = dow_pkg::RS_RUN;
					end
				end
			end
			dow_pkg::RS_POWERUP_TIMER: begin
				if (brown) begin
					nxt_rs = dow_pkg::RS_HOLD;
				end else if (lf_tick && powerup_timer_cnt_ff == POWERUP_TIMER_LAST) begin
					nxt_rs = crystal ? dow_pkg::RS_OST
					                 : dow_pkg::RS_RUN;
				end
			end
			dow_pkg::RS_OST: begin
				if (brown) begin
					nxt_rs = dow_pkg::RS_HOLD;
				end else if (osc_stable) begin
					nxt_rs = dow_pkg::RS_RUN;
				end
			end
			dow_pkg::RS_RUN: begin
				if (brown) begin
					nxt_rs = dow_pkg::RS_HOLD;
				end
			end
			default: nxt_rs = dow_pkg::RS_HOLD;
		endcase
		// a new power-on always restarts the sequence
		if (por_event) begin
			nxt_rs = dow_pkg::RS_HOLD;
		end
	end

	// sequencer state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			rs_ff <= dow_pkg::RS_HOLD;
		end else begin
			rs_ff <= nxt_rs;
		end
	end

	// power-up counter advances on time-base ticks
	always_ff @(posedge mclk) begin
		if (rst || rs_ff != dow_pkg::RS_POWERUP_TIMER) begin
			powerup_timer_cnt_ff <= '0; // re-initialised outside the timer
		end else if (lf_tick) begin
			powerup_timer_cnt_ff <= powerup_timer_cnt_ff + 1'b1;
		end
	end

	// sequencer status and device reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			powerup_timer_active_ff <= 1'b0;
			ost_active_ff  <= 1'b0;
			dev_reset_ff   <= 1'b1;
		end else begin
			powerup_timer_active_ff <= nxt_rs == dow_pkg::RS_POWERUP_TIMER;
			ost_active_ff  <= nxt_rs == dow_pkg::RS_OST;
			// a held external pin keeps reset after time-outs
			dev_reset_ff   <= (nxt_rs != dow_pkg::RS_RUN) || !external_reset_n_n;
		end
	end

	// -------------------------------------------------------------------
	// execution guard
	// -------------------------------------------------------------------
	// instruction fetches into configuration space are refused
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_blocked_ff <= 1'b0;
		end else begin
			cpu_blocked_ff <= cpu_fetch && cpu_addr >= dow_pkg::CFG_LO &&
			                  cpu_addr <= dow_pkg::CFG_HI;
		end
	end

	// -------------------------------------------------------------------
	// programming port
	// -------------------------------------------------------------------
	// only the option location takes writes or returns data, and only in programming mode
	assign opt_hit = prog_mode && prog_addr == dow_pkg::OPT_ADDR;

	// a 0 to 1 change on a protect bit lifts protection
	assign lift_data = nvm_word[dow_pkg::B_CPD] == dow_pkg::BIT_PROG &&
	                   prog_wdata[dow_pkg::B_CPD] != dow_pkg::BIT_PROG;
	assign lift_code = nvm_word[dow_pkg::B_CP] == dow_pkg::BIT_PROG &&
	                   prog_wdata[dow_pkg::B_CP] != dow_pkg::BIT_PROG;

	// write sequence: erase first when protection is lifted
	always_comb begin
		nxt_pg = pg_ff;
		case (pg_ff)
			dow_pkg::PG_IDLE: begin
				if (opt_hit && prog_wr) begin
					nxt_pg = (lift_data || lift_code) ? dow_pkg::PG_ERASE
					                                  : dow_pkg::PG_WRITE;
				end
			end
			dow_pkg::PG_ERASE: begin
				if (erase_done) begin
					nxt_pg = dow_pkg::PG_WRITE;
				end
			end
			dow_pkg::PG_WRITE: nxt_pg = dow_pkg::PG_IDLE;
			default:           nxt_pg = dow_pkg::PG_IDLE;
		endcase
	end

	// programming state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			pg_ff <= dow_pkg::PG_IDLE;
		end else begin
			pg_ff <= nxt_pg;
		end
	end

	// latch the incoming word when a write is taken
	always_ff @(posedge mclk) begin
		if (rst) begin
			wbuf_ff <= dow_pkg::ERASED_WORD;
		end else if (pg_ff == dow_pkg::PG_IDLE && opt_hit && prog_wr) begin
			wbuf_ff <= prog_wdata;
		end
	end

	// erase requests stand until the array reports done
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_erase_ff <= 1'b0;
			code_erase_ff <= 1'b0;
		end else if (pg_ff == dow_pkg::PG_IDLE && opt_hit && prog_wr) begin
			data_erase_ff <= lift_data;
			code_erase_ff <= lift_code;
		end else if (pg_ff == dow_pkg::PG_ERASE && erase_done) begin
			data_erase_ff <= 1'b0;
			code_erase_ff <= 1'b0;
		end
	end

	// commit pulse to the fuse array, only after any erase
	always_ff @(posedge mclk) begin
		if (rst) begin
			nvm_wr_ff    <= 1'b0;
			nvm_wdata_ff <= dow_pkg::ERASED_WORD;
		end else begin
			nvm_wr_ff    <= pg_ff == dow_pkg::PG_WRITE;
			nvm_wdata_ff <= wbuf_ff;
		end
	end

	// read returns the live word; other addresses read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			prog_rdata_ff <= '0;
		end else if (prog_rd && prog_mode) begin
			prog_rdata_ff <= opt_hit ? nvm_word : '0;
		end
	end

	// acknowledge reads at once, writes when committed
	always_ff @(posedge mclk) begin
		if (rst) begin
			prog_ack_ff <= 1'b0;
		end else begin
			prog_ack_ff <= (prog_rd && prog_mode) ||
			               pg_ff == dow_pkg::PG_WRITE;
		end
	end

endmodule : dow_top

// ==== verif/dow_top_sva.sv ====
// port assertions for the option word decoder
`timescale 1ns/100ps
module dow_top_sva #(
	parameter int CNT_W      = 11,  // counter width, unused here
	parameter int POWERUP_TIMER_COUNT = 1984 // ticks per time-out, unused here
) (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [13:0]       nvm_word,
	input wire logic              prog_mode,
	input wire logic [13:0]       prog_addr,
	input wire logic [13:0]       prog_wdata,
	input wire logic              prog_wr,
	input wire logic              prog_rd,
	input wire logic [13:0]       prog_rdata_ff,
	input wire logic              prog_ack_ff,
	input wire logic              nvm_wr_ff,
	input wire logic [13:0]       nvm_wdata_ff,
	input wire logic              data_erase_ff,
	input wire logic              code_erase_ff,
	input wire logic              erase_done,
	input wire logic [13:0]       cpu_addr,
	input wire logic              cpu_fetch,
	input wire logic              cpu_blocked_ff,
	input wire logic              ext_reset_pin,
	input wire logic              sleeping,
	input wire logic              wdt_wake,
	input wire logic              irq_wake,
	input wire dow_pkg::dow_opt_t opt_ff,
	input wire logic              powerup_timer_active_ff,
	input wire logic              dev_reset_ff,
	input wire logic              gpio_in_ff,
	input wire logic              osc_stop_ff,
	input wire logic              wake_ff
);
	// ---------------------------------------------------
	// helpers
	// ---------------------------------------------------
	logic take; // accepted option word write
	logic lift_d; // data protection being lifted
	logic lift_c; // code protection being lifted
	assign take   = prog_mode && prog_wr && prog_addr == 14'h2007;
	assign lift_d = !nvm_word[7] && prog_wdata[7];
	assign lift_c = !nvm_word[6] && prog_wdata[6];

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ---------------------------------------------------
	// assertions
	// ---------------------------------------------------
	opt_load_a: assert property (disable iff (1'b0)
		rst |=> opt_ff == $past(nvm_word[11:0])) else $error("option capture wrong");
	opt_hold_a: assert property (!rst |=> $stable(opt_ff))
		else $error("options moved out of reset");
	fetch_block_a: assert property (!rst |=>
		cpu_blocked_ff == $past(cpu_fetch && cpu_addr[13])) else $error("fetch guard wrong");
	rd_ans_a: assert property (prog_rd && prog_mode |=> prog_ack_ff &&
		prog_rdata_ff == ($past(prog_addr) == 14'h2007 ? $past(nvm_word) : 14'h0))
		else $error("read answer wrong");
	wr_commit_a: assert property (take && !lift_d && !lift_c |-> ##2
		nvm_wr_ff && prog_ack_ff && nvm_wdata_ff == $past(prog_wdata, 2))
		else $error("write not committed");
	data_erase_a: assert property (take && lift_d |=> data_erase_ff)
		else $error("data erase missing");
	code_erase_a: assert property (take && lift_c |=> code_erase_ff)
		else $error("code erase missing");
	erase_first_a: assert property ((data_erase_ff || code_erase_ff) &&
		erase_done |-> !nvm_wr_ff ##[1:3] nvm_wr_ff) else $error("commit order wrong");
	osc_stop_a: assert property (!rst |=> osc_stop_ff == $past(!ext_reset_pin &&
		opt_ff.reset_pin_select && opt_ff.osc_select[2])) else $error("osc stop wrong");
	wake_src_a: assert property (!rst |=> wake_ff == $past(sleeping && (wdt_wake ||
		irq_wake || (!ext_reset_pin && opt_ff.reset_pin_select)))) else $error("wake wrong");
	pin_input_a: assert property (!rst |=> gpio_in_ff ==
		$past(ext_reset_pin && !opt_ff.reset_pin_select)) else $error("pin input wrong");
	powerup_timer_gate_a: assert property ($rose(powerup_timer_active_ff) |->
		!opt_ff.powerup_timer_disable && dev_reset_ff) else $error("timer gating wrong");

	// ---------------------------------------------------
	// covers
	// ---------------------------------------------------
	erase_c: cover property (take ##1 data_erase_ff);
	powerup_timer_c: cover property (powerup_timer_active_ff);
	wake_c: cover property (wake_ff);
	block_c: cover property (cpu_blocked_ff);
endmodule : dow_top_sva

bind dow_top dow_top_sva #(.CNT_W(CNT_W), .POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT)) chk_u (
	.mclk(mclk), .rst(rst), .nvm_word(nvm_word), .prog_mode(prog_mode),
	.prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_wr(prog_wr),
	.prog_rd(prog_rd), .prog_rdata_ff(prog_rdata_ff), .prog_ack_ff(prog_ack_ff),
	.nvm_wr_ff(nvm_wr_ff), .nvm_wdata_ff(nvm_wdata_ff), .erase_done(erase_done),
	.data_erase_ff(data_erase_ff), .code_erase_ff(code_erase_ff),
	.cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch), .cpu_blocked_ff(cpu_blocked_ff),
	.ext_reset_pin(ext_reset_pin), .sleeping(sleeping), .wdt_wake(wdt_wake),
	.irq_wake(irq_wake), .opt_ff(opt_ff), .powerup_timer_active_ff(powerup_timer_active_ff),
	.dev_reset_ff(dev_reset_ff), .gpio_in_ff(gpio_in_ff),
	.osc_stop_ff(osc_stop_ff), .wake_ff(wake_ff));

// ==== verif/dow_top_bench.sv ====
// self-checking bench for the option word decoder
`timescale 1ns/100ps
module dow_top_bench;
	localparam int PC = 4; // shortened power-up count
	logic mclk, rst, prog_mode, prog_wr, prog_rd, erase_done, cpu_fetch;
	logic por_event, vdd_low, lf_tick, osc_stable, ext_reset_pin;
	logic sleeping, wdt_wake, irq_wake, prog_ack_ff, nvm_wr_ff;
	logic data_erase_ff, code_erase_ff, cpu_blocked_ff, bor_active_ff;
	logic powerup_timer_active_ff, ost_active_ff, dev_reset_ff, gpio_in_ff;
	logic osc_stop_ff, wake_ff, wdt_run_ff;
	logic [13:0] nvm_word, prog_addr, prog_wdata, cpu_addr, w, nw;
	logic [13:0] prog_rdata_ff, nvm_wdata_ff;
	logic [7:0]  power_control_reg; // software brown-out bit at 4
	dow_pkg::dow_opt_t opt_ff; // decoded options
	int err_total, comparisons, cycles, i, j, k;

	dow_top #(.CNT_W(11), .POWERUP_TIMER_COUNT(PC)) dut_u (
		.mclk(mclk), .rst(rst), .nvm_word(nvm_word), .prog_mode(prog_mode),
		.prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_wr(prog_wr),
		.prog_rd(prog_rd), .prog_rdata_ff(prog_rdata_ff),
		.prog_ack_ff(prog_ack_ff), .nvm_wr_ff(nvm_wr_ff),
		.nvm_wdata_ff(nvm_wdata_ff), .data_erase_ff(data_erase_ff),
		.code_erase_ff(code_erase_ff), .erase_done(erase_done),
		.cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
		.cpu_blocked_ff(cpu_blocked_ff), .por_event(por_event),
		.vdd_low(vdd_low), .lf_tick(lf_tick), .osc_stable(osc_stable),
		.ext_reset_pin(ext_reset_pin), .sleeping(sleeping),
		.wdt_wake(wdt_wake), .irq_wake(irq_wake),
		.power_control_reg(power_control_reg), .opt_ff(opt_ff),
		.bor_active_ff(bor_active_ff), .powerup_timer_active_ff(powerup_timer_active_ff),
		.ost_active_ff(ost_active_ff), .dev_reset_ff(dev_reset_ff),
		.gpio_in_ff(gpio_in_ff), .osc_stop_ff(osc_stop_ff),
		.wake_ff(wake_ff), .wdt_run_ff(wdt_run_ff));

	// ---------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	// ---------------------------------------------------
	// helpers
	// ---------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [13:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	// expected brown-out arming per select code
	function automatic logic exp_arm(input logic [1:0] c, input logic s, p);
		return c == 2'h3 || (c == 2'h2 && !s) || (c == 2'h1 && p);
	endfunction : exp_arm

	// wait out the start-up timers, counting each phase
	task automatic run_seq(input logic [13:0] v);
		int np, no, n;
		np = 0;
		no = 0;
		osc_stable = 1'b0;
		for (n = 0; n < 60 && dev_reset_ff !== 1'b0; n++) begin
			cyc(1);
			np += powerup_timer_active_ff;
			no += ost_active_ff;
			if (no > 2) osc_stable = 1'b1;
		end
		chk("released", 14'h0, {13'h0, dev_reset_ff});
		chk("powerup_timer length", v[4] ? 14'h0 : 14'(PC), 14'(np));
		chk("ost seen", {13'h0, v[2:0] < 3'h3}, {13'h0, no > 2});
	endtask : run_seq

	task automatic prog_read(input logic [13:0] a, e);
		prog_addr = a;
		prog_rd = 1'b1;
		cyc(1);
		prog_rd = 1'b0;
		chk("read ack", {13'h0, prog_mode}, {13'h0, prog_ack_ff});
		chk("read data", e, prog_rdata_ff);
		cyc(1);
	endtask : prog_read

	// ---------------------------------------------------
	// main sequence
	// ---------------------------------------------------
	initial begin
		{rst, prog_mode, prog_wr, prog_rd, erase_done, cpu_fetch} = 6'h20;
		{por_event, vdd_low, osc_stable, sleeping, wdt_wake, irq_wake} = 6'h0;
		{lf_tick, ext_reset_pin} = 2'h3; // tick every cycle
		{nvm_word, prog_addr, prog_wdata, cpu_addr} = '0;
		power_control_reg = 8'h10;
		{err_total, comparisons, cycles} = '0;
		void'($urandom(32'h19048C79));
		// option decode and start-up, every select code
		for (i = 0; i < 8; i++) begin
			w = 14'($urandom);
			w[9:8] = i[1:0];
			w[2:0] = i[2:0];
			w[5:4] = {i[0], i[1] ^ i[2]};
			nvm_word = w;
			rst = 1'b1;
			cyc(12);
			rst = 1'b0;
			chk("options", {2'h0, w[11:0]}, {2'h0, opt_ff});
			run_seq(w);
			chk("watchdog", {13'h0, w[3]}, {13'h0, wdt_run_ff});
			for (j = 0; j < 4; j++) begin
				sleeping = j[0];
				power_control_reg = {3'($urandom), j[1], 4'($urandom)};
				cyc(3);
				chk("bor armed", {13'h0, exp_arm(w[9:8], j[0], j[1])}, {13'h0, bor_active_ff});
			end
			sleeping = 1'b0;
			power_control_reg = 8'h10;
			vdd_low = 1'b1;
			cyc(3);
			chk("brownout", {13'h0, w[9:8] != 2'h0}, {13'h0, dev_reset_ff});
			vdd_low = 1'b0;
			if (w[9:8] != 2'h0) run_seq(w);
			ext_reset_pin = 1'b0;
			cyc(2);
			chk("pin reset", {13'h0, w[5]}, {13'h0, dev_reset_ff});
			chk("osc stop", {13'h0, w[5] & w[2]}, {13'h0, osc_stop_ff});
			sleeping = 1'b1;
			cyc(2);
			chk("pin wake", {13'h0, w[5]}, {13'h0, wake_ff});
			{ext_reset_pin, wdt_wake} = 2'h3;
			cyc(2);
			chk("pin input", {13'h0, !w[5]}, {13'h0, gpio_in_ff});
			chk("wdt wake", 14'h1, {13'h0, wake_ff});
			{wdt_wake, irq_wake} = 2'h1;
			cyc(2);
			chk("irq wake", 14'h1, {13'h0, wake_ff});
			{irq_wake, sleeping} = 2'h0;
			// a fresh power-on restarts the whole time-out sequence
			por_event = 1'b1;
			cyc(1);
			por_event = 1'b0;
			chk("por hold", 14'h1, {13'h0, dev_reset_ff});
			run_seq(w);
		end
		// programming: data lift, code lift, plain write
		for (k = 0; k < 3; k++) begin
			w = 14'($urandom);
			nw = 14'($urandom);
			w[7:6] = (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h3;
			nw[7:6] = (k == 2) ? 2'h0 : 2'h3;
			nvm_word = w;
			prog_mode = 1'b1;
			prog_read(14'h2007, w);
			prog_read(14'h2006, 14'h0);
			prog_addr = 14'h2007;
			prog_wdata = nw;
			prog_wr = 1'b1;
			cyc(1);
			prog_wr = 1'b0;
			chk("data erase", {13'h0, k == 0}, {13'h0, data_erase_ff});
			chk("code erase", {13'h0, k == 1}, {13'h0, code_erase_ff});
			cyc(1);
			if (k < 2) begin
				chk("early commit", 14'h0, {13'h0, nvm_wr_ff});
				cyc(3);
				erase_done = 1'b1;
				cyc(1);
				erase_done = 1'b0;
				cyc(1);
			end
			chk("commit", 14'h1, {13'h0, nvm_wr_ff & prog_ack_ff});
			chk("commit word", nw, nvm_wdata_ff);
			chk("erase off", 14'h0, {13'h0, data_erase_ff | code_erase_ff});
			cyc(1);
		end
		// refused writes: wrong address, then outside programming
		for (k = 0; k < 2; k++) begin
			prog_mode = !k[0];
			prog_addr = k[0] ? 14'h2007 : 14'h2006;
			prog_wr = 1'b1;
			cyc(1);
			prog_wr = 1'b0;
			cyc(1);
			chk("refused write", 14'h0, {13'h0, nvm_wr_ff});
		end
		prog_read(14'h2007, 14'h0);
		// instruction fetches around the configuration space
		for (k = 0; k < 16; k++) begin
			cpu_addr = (k < 2) ? (k[0] ? 14'h2000 : 14'h1FFF) : 14'($urandom);
			cpu_fetch = 1'b1;
			cyc(1);
			chk("fetch blocked", {13'h0, cpu_addr[13]}, {13'h0, cpu_blocked_ff});
		end
		cpu_fetch = 1'b0;
		cyc(2);
		print_verdict();
	end
endmodule : dow_top_bench
